//--- design/brk_pkg.sv
// package for the address breakpoint unit: register map, field positions, types
// assumes a 32-bit axi4-lite register bus, byte registers in the low lane
package brk_pkg;
   // register byte addresses (word aligned)
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_ADDR_H = 8'h04;
   localparam logic [7:0] OFF_ADDR_L = 8'h08;
   localparam logic [7:0] OFF_AUX    = 8'h0c;
   localparam logic [7:0] OFF_WSTAT  = 8'h10;
   localparam logic [7:0] OFF_FLAG   = 8'h14;
   // field positions
   localparam int BIT_ENABLE  = 7;
   localparam int BIT_ACTIVE  = 6;
   localparam int BIT_WDOG    = 0;
   localparam int BIT_WEXIT   = 1;
   localparam int BIT_CLRFLAG = 7;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   // vectors
   localparam logic [15:0] VEC_USER = 16'hfffc;
   localparam logic [15:0] VEC_MON  = 16'hfefc;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [15:0] addr;    // core address bus
      logic        pc_addr; // address comes from the program counter
      logic        opcode;  // cycle fetches an opcode
      logic        insn_start; // first cycle of a new instruction
   } core_bus_s;
endpackage

//--- design/brk_match.sv
// address comparator for the breakpoint unit
// assumes inputs are already on aclk; the hit is combinational, caller registers
`timescale 1ns/1ps
`default_nettype none
module brk_match
   import brk_pkg::*;
#(
   parameter int AW = 16
) (
   input  wire logic [AW-1:0] addr,
   input  wire logic [AW-1:0] target,
   input  wire logic          qualify,
   output logic               hit
);
   // no flop here: a second stage would let a matched opcode run to
   // completion before the break request reaches the core
   always_comb begin
      hit = qualify && (addr == target);
   end
endmodule
`default_nettype wire

//--- design/brk_unit.sv
// address breakpoint unit: compare, break request, freeze and flag gating
// assumes the core presents one bus cycle per clock and a monitor-mode level
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module brk_unit
   import brk_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire core_bus_s   core_bus,
   input  wire logic        monitor_mode,
   input  wire logic        low_power,
   input  wire logic        wait_exit,
   output logic             breakpoint_request,
   output logic [15:0]      break_vector,
   output logic             timer_freeze,
   output logic             watchdog_hold,
   output logic             flag_clear_allow
);
   logic       enable_r;
   logic       active_r;
   logic [7:0] addr_h_r;
   logic [7:0] addr_l_r;
   logic       wdog_r;
   logic       wexit_r;
   logic       clrflag_r;
   logic       in_break_r;
   logic       pend_match_r;
   logic       sw_pend_r;
   logic [7:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic       w_strb0_r;
   logic       aw_full_r;
   logic       w_full_r;
   logic       hit;
   logic       wr_go;
   logic       mon_s1_r;
   logic       mon_s2_r;
   logic       match_block_r;
   logic       qual;

   // the write lands when both halves are held
   assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;

   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
      is_reg = (a == off);
   endfunction

   function automatic logic known(input logic [7:0] a);
      known = is_reg(a, OFF_CTRL) || is_reg(a, OFF_ADDR_H) || is_reg(a, OFF_ADDR_L)
           || is_reg(a, OFF_AUX) || is_reg(a, OFF_WSTAT) || is_reg(a, OFF_FLAG);
   endfunction

   // monitor level comes from another block's reset latch; synchronise it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mon_s1_r <= 1'b0;
         mon_s2_r <= 1'b0;
      end else begin
         mon_s1_r <= monitor_mode;
         mon_s2_r <= mon_s1_r;
      end
   end

   // address and data accepted in either order; ready is a flop that
   // mirrors an empty holding slot, low during and just after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r     <= 1'b0;
         w_full_r      <= 1'b0;
         aw_addr_r     <= RST_BYTE;
         w_data_r      <= RST_BYTE;
         w_strb0_r     <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_go || !aw_full_r) begin
            aw_full_r     <= 1'b0;
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r     <= 1'b1;
            w_data_r     <= s_axi_wdata[7:0];
            w_strb0_r    <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else if (wr_go || !w_full_r) begin
            w_full_r     <= 1'b0;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // write response, slverr for unmapped addresses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= known(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // only the low byte lane carries register data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_r  <= 1'b0;
         addr_h_r  <= RST_BYTE;
         addr_l_r  <= RST_BYTE;
         wdog_r    <= 1'b0;
         clrflag_r <= 1'b0;
      end else if (wr_go && w_strb0_r) begin
         if (is_reg(aw_addr_r, OFF_CTRL)) enable_r <= w_data_r[BIT_ENABLE];
         if (is_reg(aw_addr_r, OFF_ADDR_H)) addr_h_r <= w_data_r;
         if (is_reg(aw_addr_r, OFF_ADDR_L)) addr_l_r <= w_data_r;
         if (is_reg(aw_addr_r, OFF_AUX)) wdog_r <= w_data_r[BIT_WDOG];
         if (is_reg(aw_addr_r, OFF_FLAG)) clrflag_r <= w_data_r[BIT_CLRFLAG];
      end
   end

   // only pc-driven cycles qualify; the bus is frozen in low power, so no
   // match is possible there though enable stays set
   assign qual = enable_r && core_bus.pc_addr && !low_power
              && !match_block_r;

   brk_match #(.AW(16)) u_match (
      .addr    (core_bus.addr),
      .target  ({addr_h_r, addr_l_r}),
      .qualify (qual),
      .hit     (hit)
   );

   // active bit: a match that arrives with a clearing write wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_r  <= 1'b0;
         sw_pend_r <= 1'b0;
      end else begin
         if (hit && !active_r) begin
            active_r <= 1'b1;
         end else if (wr_go && w_strb0_r && is_reg(aw_addr_r, OFF_CTRL)) begin
            active_r <= w_data_r[BIT_ACTIVE];
         end
         // software set: request at next instruction boundary
         if (wr_go && w_strb0_r && is_reg(aw_addr_r, OFF_CTRL) && w_data_r[BIT_ACTIVE]
             && !in_break_r) begin
            sw_pend_r <= 1'b1;
         end else if (sw_pend_r && core_bus.insn_start) begin
            sw_pend_r <= 1'b0;
         end
      end
   end

   // an operand match waits for the next instruction boundary
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_match_r <= 1'b0;
      end else if (hit && !active_r && !in_break_r && !core_bus.opcode) begin
         pend_match_r <= 1'b1;
      end else if (pend_match_r && core_bus.insn_start) begin
         pend_match_r <= 1'b0;
      end
   end

   // a taken match blocks its address until software rewrites either byte,
   // so clearing active alone gives no repeat break after the return
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_block_r <= 1'b0;
      end else if (hit && !active_r && !in_break_r) begin
         match_block_r <= 1'b1;
      end else if (wr_go && w_strb0_r
                   && (is_reg(aw_addr_r, OFF_ADDR_H) || is_reg(aw_addr_r, OFF_ADDR_L))) begin
         match_block_r <= 1'b0;
      end
   end

   // an opcode match is caught in its own fetch cycle, so the core never
   // completes it; operand and software breaks wait for the next boundary
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         breakpoint_request <= 1'b0;
         in_break_r         <= 1'b0;
         break_vector       <= VEC_USER;
      end else begin
         breakpoint_request <= 1'b0;
         if (!in_break_r && core_bus.insn_start
             && ((hit && !active_r) || pend_match_r || sw_pend_r)) begin
            breakpoint_request <= 1'b1;
            in_break_r         <= 1'b1;
            break_vector       <= mon_s2_r ? VEC_MON : VEC_USER;
         end else if (in_break_r && !active_r && core_bus.insn_start) begin
            in_break_r <= 1'b0;
         end
      end
   end

   // freeze, watchdog hold and clear permission follow the break state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_freeze     <= 1'b0;
         watchdog_hold    <= 1'b0;
         flag_clear_allow <= 1'b1;
      end else begin
         timer_freeze     <= in_break_r;
         watchdog_hold    <= in_break_r && mon_s2_r && wdog_r;
         flag_clear_allow <= !in_break_r || clrflag_r;
      end
   end

   // wait exit flag: set when break ends wait, cleared when break ends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wexit_r <= 1'b0;
      end else if (wait_exit && (pend_match_r || sw_pend_r || in_break_r)) begin
         wexit_r <= 1'b1;
      end else if (!in_break_r) begin
         wexit_r <= 1'b0;
      end
   end

   // read channel, one cycle after address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata  <= 32'h0;
            unique case (1'b1)
               is_reg(s_axi_araddr, OFF_CTRL):
                  s_axi_rdata[7:6] <= {enable_r, active_r};
               is_reg(s_axi_araddr, OFF_ADDR_H): s_axi_rdata[7:0] <= addr_h_r;
               is_reg(s_axi_araddr, OFF_ADDR_L): s_axi_rdata[7:0] <= addr_l_r;
               is_reg(s_axi_araddr, OFF_AUX): s_axi_rdata[BIT_WDOG] <= wdog_r;
               is_reg(s_axi_araddr, OFF_WSTAT): s_axi_rdata[BIT_WEXIT] <= wexit_r;
               is_reg(s_axi_araddr, OFF_FLAG): s_axi_rdata[BIT_CLRFLAG] <= clrflag_r;
               default: s_axi_rdata <= 32'h0;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // timer freeze must follow break state one cycle later
   a_timer_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
      in_break_r |=> timer_freeze) else $error("timer not frozen in break");
   a_req_boundary: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(breakpoint_request) |-> $past(core_bus.insn_start))
      else $error("request off instruction boundary");
   a_req_vector: assert property (@(posedge aclk) disable iff (!aresetn)
      breakpoint_request |-> break_vector == ($past(mon_s2_r) ? VEC_MON : VEC_USER))
      else $error("wrong break vector");
   a_wdog_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      watchdog_hold |-> $past(in_break_r && mon_s2_r && wdog_r))
      else $error("watchdog held without cause");
   a_flag_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      ($past(in_break_r) && !$past(clrflag_r)) |-> !flag_clear_allow)
      else $error("flag clear allowed in break");
   a_match_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      (hit && !active_r) |=> active_r) else $error("match did not set active");
   a_no_lowpow: assert property (@(posedge aclk) disable iff (!aresetn)
      low_power |-> !hit) else $error("match during low power");
   a_data_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
      !core_bus.pc_addr |-> !hit) else $error("data access matched");
endmodule
`default_nettype wire

//--- verif/core_model.sv
// core model: steps a program counter through two-byte instructions
// assumes brk_pkg; the core jumps to the vector on each break request
`timescale 1ns/1ps
`default_nettype none
module core_model
   import brk_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        jump,
   input  wire logic [15:0] jump_addr,
   input  wire logic        data_sel,
   input  wire logic        low_power,
   input  wire logic        breakpoint_request,
   input  wire logic [15:0] break_vector,
   output core_bus_s        core_bus
);
   logic [15:0] pc_r;
   logic        ph_r;
   // pc holds in low power, so no new address shows on the bus
   always_ff @(posedge aclk) begin
      if (!aresetn || jump) begin
         pc_r <= aresetn ? jump_addr : 16'h0000;
         ph_r <= 1'b0;
      end else if (breakpoint_request) begin
         pc_r <= break_vector; // vector fetch on request
         ph_r <= 1'b0;
      end else if (!low_power) begin
         pc_r <= pc_r + 16'h0001;
         ph_r <= ~ph_r;
      end
   end
   // even phase is opcode, odd is operand; data cycles drop pc_addr
   assign core_bus = '{addr: pc_r, pc_addr: !data_sel, opcode: !ph_r,
                       insn_start: !ph_r && !low_power};
endmodule
`default_nettype wire

//--- verif/address_breakpoint_unit_tb.sv
// testbench for the breakpoint unit: axi4-lite master, core model, checks
// assumes brk_pkg offsets and a 125 MHz aclk
`timescale 1ns/1ps
`default_nettype none
module address_breakpoint_unit_tb
   import brk_pkg::*;
;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rd;
   logic [3:0]  wstrb = 4'hf;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rs;
   logic [31:0] rdata, r;
   logic        mon = 1'b0, lowp = 1'b0, wexit = 1'b0, jump = 1'b0, dsel = 1'b0;
   logic [15:0] jaddr = 16'h0, vec, last_vec, bp, last_pc;
   logic        req, tfrz, wdh, fca;
   core_bus_s   cbus;
   int          fail_count = 0, tests_run = 0, req_cnt = 0, seed = 98, base;

   // 8 ns period
   always #4 aclk = ~aclk;

   brk_unit DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .core_bus(cbus), .monitor_mode(mon),
      .low_power(lowp), .wait_exit(wexit), .breakpoint_request(req),
      .break_vector(vec), .timer_freeze(tfrz), .watchdog_hold(wdh),
      .flag_clear_allow(fca));

   core_model core (.aclk(aclk), .aresetn(aresetn), .jump(jump), .jump_addr(jaddr),
      .data_sel(dsel), .low_power(lowp), .breakpoint_request(req),
      .break_vector(vec), .core_bus(cbus));

   // count requests mid-cycle, where the registered pulse has settled
   always @(negedge aclk) begin
      if (req === 1'b1) begin
         req_cnt++;
         last_vec = vec;
         last_pc = cbus.addr;
      end
   end

   function automatic logic [15:0] exp_vec(input logic m);
      return m ? VEC_MON : VEC_USER;
   endfunction

   // the core must not finish an opcode-matched instruction: an opcode match stops
   // it at its operand, an operand match stops the following one likewise
   function automatic logic [15:0] exp_pc(input logic [15:0] a, input logic opnd);
      return a + (opnd ? 16'h0002 : 16'h0001);
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // ready is sampled mid-cycle, valid released right after the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ha = 1'b0, hw = 1'b0, bv = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         ha = ha | (awvalid & awready);
         hw = hw | (wvalid & wready);
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end while (!(ha && hw));
      do begin
         @(negedge aclk);
         bv = bvalid;
         rs = bresp;
         @(posedge aclk);
      end while (bv !== 1'b1);
      bready <= 1'b0;
   endtask

   task automatic rdr(input logic [7:0] a);
      logic h = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         h = arready;
         @(posedge aclk);
      end while (h !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         h = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge aclk);
      end while (h !== 1'b1);
      rready <= 1'b0;
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // a hung handshake ends the run well past the expected run of under a thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      report_and_stop();
   end

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk("vec_rst", vec, VEC_USER);
      chk("fca_rst", fca, 1'b1);
      chk("frz_rst", tfrz, 1'b0);
      for (int i = 0; i < 6; i++) begin
         rdr(8'(i * 4));
         chk("reg_rst", rd, 32'h0);
      end
      rdr(8'h18);
      chk("unmapped", {rd[29:0], rs}, {30'h0, RESP_SLVERR});
      wr(8'h18, 32'h0000_0001);
      chk("wr_unmapped", rs, RESP_SLVERR);
      // random address bytes read back whole
      repeat (4) begin
         r = $random(seed);
         wr(OFF_ADDR_H, {24'h0, r[15:8]});
         wr(OFF_ADDR_L, {24'h0, r[7:0]});
         rdr(OFF_ADDR_H);
         chk("addr_h", rd, {24'h0, r[15:8]});
         rdr(OFF_ADDR_L);
         chk("addr_l", rd, {24'h0, r[7:0]});
      end
      wr(OFF_WSTAT, 32'h0000_00ff);
      chk("bresp_ok", rs, RESP_OKAY);
      rdr(OFF_WSTAT);
      chk("wstat_ro", rd, 32'h0);
      // even passes break on address match, odd ones by software
      for (int i = 0; i < 6; i++) begin
         r = $random(seed);
         bp = {4'h1, r[11:0]};
         mon <= r[12]; // monitor level from the system
         wexit <= (i == 3);
         wr(OFF_AUX, {31'h0, r[13]});
         wr(OFF_FLAG, {24'h0, r[14], 7'h0});
         wr(OFF_ADDR_H, {24'h0, bp[15:8]});
         wr(OFF_ADDR_L, {24'h0, bp[7:0]});
         base = req_cnt;
         if (i[0]) begin
            wr(OFF_CTRL, 32'h0000_0040);
         end else begin
            wr(OFF_CTRL, 32'h0000_0080);
            jaddr <= bp - ((i == 4) ? 16'h0003 : 16'h0004); // pass 4 hits an operand
            jump <= 1'b1;
            @(posedge aclk);
            jump <= 1'b0;
         end
         repeat (20) @(posedge aclk);
         @(negedge aclk);
         chk("req", req_cnt, base + 1);
         chk("vec", last_vec, exp_vec(r[12]));
         if (!i[0]) chk("brk_pc", last_pc, exp_pc(bp, i == 4));
         chk("frz", tfrz, 1'b1);
         chk("wdog", wdh, r[12] & r[13]);
         chk("fca", fca, r[14]);
         rdr(OFF_CTRL);
         chk("ctrl", rd, i[0] ? 32'h40 : 32'hc0);
         rdr(OFF_WSTAT);
         chk("wexit", rd, (i == 3) ? 32'h2 : 32'h0);
         wr(OFF_CTRL, i[0] ? 32'h0 : 32'h80); // cleared before return
         repeat (10) @(posedge aclk);
         @(negedge aclk);
         chk("frz_end", tfrz, 1'b0);
         chk("fca_end", fca, 1'b1);
         @(posedge aclk);
         wexit <= 1'b0;
         if (!i[0]) begin
            // same address, active cleared: the match must not fire again
            base = req_cnt;
            jump <= 1'b1;
            @(posedge aclk);
            jump <= 1'b0;
            repeat (12) @(posedge aclk);
            chk("no_repeat", req_cnt, base);
            wr(OFF_CTRL, 32'h0);
         end
      end
      // data access, low power, disabled: none may break
      for (int k = 0; k < 3; k++) begin
         wr(OFF_CTRL, (k == 2) ? 32'h0 : 32'h80);
         base = req_cnt;
         dsel <= (k == 0);
         lowp <= (k == 1);
         jaddr <= (k == 1) ? bp : bp - 16'h0004;
         jump <= 1'b1;
         @(posedge aclk);
         jump <= 1'b0;
         repeat (20) @(posedge aclk);
         chk("noreq", req_cnt, base);
         rdr(OFF_CTRL);
         chk("en_kept", rd, (k == 2) ? 32'h0 : 32'h80);
         wr(OFF_CTRL, 32'h0);
         dsel <= 1'b0;
         lowp <= 1'b0;
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
